// >>> rtl/ecm_mode_unit.sv
/*
   Mode decoding, capture, compare actions and PWM output polarity.
   Assumes free-running synchronous timer counts and a PWM waveform made elsewhere from timer 2.
*/
`timescale 1ns/1ps

module ecm_mode_unit
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Time bases
   input wire logic [15:0] timer_one_count_i,
   input wire logic [15:0] timer_three_count_i,
   input wire logic pwm_mod_i,
   // Capture/compare pin, shared with output A
   input wire logic capture_compare_pin_i,
   output logic capture_compare_pin_o,
   output logic capture_compare_pin_oe_o,
   // Further PWM outputs
   output logic pwm_out_b_o,
   output logic pwm_out_b_oe_o,
   output logic pwm_out_c_o,
   output logic pwm_out_c_oe_o,
   output logic pwm_out_d_o,
   output logic pwm_out_d_oe_o,
   // Events to the system
   output logic match_capture_flag_o,
   output logic timer_one_reset_o,
   output logic timer_three_reset_o,
   output logic adc_start_o
);

   typedef struct packed {
      logic [1:0] output_config_field;
      logic [1:0] duty_lsb;
      logic [3:0] mode_select_field;
      logic [15:0] capture_compare_value;
      logic use_timer_three;
      logic match_capture_flag;
      logic cmp_latch;
      logic match_prev;
      logic [7:0] rdata;
      logic adc_start;
      logic t1_reset;
      logic t3_reset;
      logic pin_lvl;
      logic pin_oe;
      logic b_lvl;
      logic b_oe;
      logic c_lvl;
      logic c_oe;
      logic d_lvl;
      logic d_oe;
   } ecm_state_s;

   ecm_state_s s;
   ecm_state_s next_s;
   logic capture_evt;
   logic [15:0] timer_sel;
   logic match;
   logic match_evt;
   logic [3:0] new_mode;
   logic [3:0] act;
   logic [3:0] drive;

   // ==========================================================
   // Edge detection and prescaler
   // sampled straight from pin wire
   ecm_capture_event u_event
   (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .pin_i(capture_compare_pin_i),
      .mode_i(s.mode_select_field),
      .capture_o(capture_evt)
   );

   // ==========================================================
   // Next state
   always_comb
   begin
      next_s = s;
      next_s.adc_start = 1'b0;
      next_s.t1_reset = 1'b0;
      next_s.t3_reset = 1'b0;
      next_s.rdata = ecm_pkg::RDATA_RST;
      new_mode = reg_wdata_i[ecm_pkg::CTRL_MODE_LSB +: 4];

      // timer 1 or 3 for capture/compare
      timer_sel = s.use_timer_three ? timer_three_count_i : timer_one_count_i;

      match = ecm_pkg::is_compare(s.mode_select_field) && (s.capture_compare_value == timer_sel);
      // A stalled timer would otherwise act every cycle
      match_evt = match & ~s.match_prev;
      next_s.match_prev = match;

      // Register writes
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            ecm_pkg::OFS_CTRL:
            begin
               next_s.output_config_field = reg_wdata_i[ecm_pkg::CTRL_OCFG_LSB +: 2];
               next_s.duty_lsb = reg_wdata_i[ecm_pkg::CTRL_DUTY_LSB +: 2];
               next_s.mode_select_field = new_mode;
               if (new_mode != s.mode_select_field)
               begin
                  if (new_mode == ecm_pkg::MODE_SET_ON_MATCH)
                     next_s.cmp_latch = 1'b0;
                  if (new_mode == ecm_pkg::MODE_CLR_ON_MATCH)
                     next_s.cmp_latch = 1'b1;
               end
            end
            ecm_pkg::OFS_VAL_LO: next_s.capture_compare_value[7:0] = reg_wdata_i;
            ecm_pkg::OFS_VAL_HI: next_s.capture_compare_value[15:8] = reg_wdata_i;
            ecm_pkg::OFS_TSEL: next_s.use_timer_three = reg_wdata_i[ecm_pkg::TSEL_BIT];
            ecm_pkg::OFS_STATUS:
            begin
               if (reg_wdata_i[ecm_pkg::STAT_FLAG_BIT])
                  next_s.match_capture_flag = 1'b0;
            end
            default: next_s.rdata = ecm_pkg::RDATA_RST;
         endcase
      end

      // Compare actions, after writes so a set beats a clear
      if (match_evt)
      begin
         case (s.mode_select_field)
            ecm_pkg::MODE_TOGGLE: next_s.cmp_latch = ~s.cmp_latch;
            ecm_pkg::MODE_SET_ON_MATCH: next_s.cmp_latch = 1'b1;
            ecm_pkg::MODE_CLR_ON_MATCH: next_s.cmp_latch = 1'b0;
            ecm_pkg::MODE_SPECIAL:
            begin
               next_s.t1_reset = ~s.use_timer_three;
               next_s.t3_reset = s.use_timer_three;
               next_s.adc_start = 1'b1;
            end
            default: next_s.cmp_latch = next_s.cmp_latch;
         endcase
         next_s.match_capture_flag = 1'b1;
      end

      // Capture overrides a same-cycle value write
      if (capture_evt && ecm_pkg::is_capture(s.mode_select_field))
      begin
         next_s.capture_compare_value = timer_sel;
         next_s.match_capture_flag = 1'b1;
      end

      if (next_s.mode_select_field == ecm_pkg::MODE_OFF)
      begin
         next_s.cmp_latch = 1'b0;
         next_s.match_prev = 1'b0;
      end

      // Register reads, data in the following cycle
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            ecm_pkg::OFS_CTRL:
               next_s.rdata = {s.output_config_field, s.duty_lsb, s.mode_select_field};
            ecm_pkg::OFS_VAL_LO: next_s.rdata = s.capture_compare_value[7:0];
            ecm_pkg::OFS_VAL_HI: next_s.rdata = s.capture_compare_value[15:8];
            ecm_pkg::OFS_TSEL:
            begin
               next_s.rdata = ecm_pkg::RDATA_RST;
               next_s.rdata[ecm_pkg::TSEL_BIT] = s.use_timer_three;
            end
            ecm_pkg::OFS_STATUS:
            begin
               next_s.rdata = ecm_pkg::RDATA_RST;
               next_s.rdata[ecm_pkg::STAT_FLAG_BIT] = s.match_capture_flag;
               next_s.rdata[ecm_pkg::STAT_LATCH_BIT] = s.cmp_latch;
            end
            default: next_s.rdata = ecm_pkg::RDATA_RST;
         endcase
      end

      // ==========================================================
      // Pin drive, computed from the next mode so outputs track it
      // active set per output configuration
      act = 4'h0;
      drive = 4'h0;
      if (ecm_pkg::is_pwm(next_s.mode_select_field))
      begin
         case (next_s.output_config_field)
            // Steering of single mode lives outside this block
            ecm_pkg::OCFG_SINGLE:
            begin
               act = {4{pwm_mod_i}};
               drive = 4'hF;
            end
            ecm_pkg::OCFG_FWD:
            begin
               act = {pwm_mod_i, 1'b0, 1'b0, 1'b1};
               drive = 4'hF;
            end
            // No dead band here; that is applied downstream
            ecm_pkg::OCFG_HALF:
            begin
               act = {1'b0, 1'b0, ~pwm_mod_i, pwm_mod_i};
               drive = 4'h3;
            end
            ecm_pkg::OCFG_REV:
            begin
               act = {1'b0, 1'b1, pwm_mod_i, 1'b0};
               drive = 4'hF;
            end
            default:
            begin
               act = 4'h0;
               drive = 4'h0;
            end
         endcase
         act[0] = act[0] ^ next_s.mode_select_field[1];
         act[2] = act[2] ^ next_s.mode_select_field[1];
         act[1] = act[1] ^ next_s.mode_select_field[0];
         act[3] = act[3] ^ next_s.mode_select_field[0];
      end
      else
      begin
         case (next_s.mode_select_field)
            ecm_pkg::MODE_TOGGLE, ecm_pkg::MODE_SET_ON_MATCH, ecm_pkg::MODE_CLR_ON_MATCH:
            begin
               act[0] = next_s.cmp_latch;
               drive[0] = 1'b1;
            end
            default:
            begin
               act[0] = 1'b0;
               drive[0] = 1'b0;
            end
         endcase
      end
      next_s.pin_lvl = act[0];
      next_s.pin_oe = drive[0];
      next_s.b_lvl = act[1];
      next_s.b_oe = drive[1];
      next_s.c_lvl = act[2];
      next_s.c_oe = drive[2];
      next_s.d_lvl = act[3];
      next_s.d_oe = drive[3];
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         s <= '0;
         s.output_config_field <= ecm_pkg::CTRL_RST[ecm_pkg::CTRL_OCFG_LSB +: 2];
         s.duty_lsb <= ecm_pkg::CTRL_RST[ecm_pkg::CTRL_DUTY_LSB +: 2];
         s.mode_select_field <= ecm_pkg::CTRL_RST[ecm_pkg::CTRL_MODE_LSB +: 4];
         s.capture_compare_value <= ecm_pkg::VAL_RST;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata_o = s.rdata;
   assign capture_compare_pin_o = s.pin_lvl;
   assign capture_compare_pin_oe_o = s.pin_oe;
   assign pwm_out_b_o = s.b_lvl;
   assign pwm_out_b_oe_o = s.b_oe;
   assign pwm_out_c_o = s.c_lvl;
   assign pwm_out_c_oe_o = s.c_oe;
   assign pwm_out_d_o = s.d_lvl;
   assign pwm_out_d_oe_o = s.d_oe;
   assign match_capture_flag_o = s.match_capture_flag;
   assign timer_one_reset_o = s.t1_reset;
   assign timer_three_reset_o = s.t3_reset;
   assign adc_start_o = s.adc_start;

endmodule

// >>> inc/ecm_pkg.sv
/*
   Constants, register map and mode decoding for the capture/compare mode unit.
   Assumes an 8-bit register port with a 3-bit address and 16-bit timer inputs.
*/
package ecm_pkg;

   // ==========================================================
   // Register port
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam logic [2:0] OFS_CTRL = 3'h0;
   localparam logic [2:0] OFS_VAL_LO = 3'h1;
   localparam logic [2:0] OFS_VAL_HI = 3'h2;
   localparam logic [2:0] OFS_TSEL = 3'h3;
   localparam logic [2:0] OFS_STATUS = 3'h4;

   // ==========================================================
   // Field positions
   localparam int unsigned CTRL_MODE_LSB = 0;
   localparam int unsigned CTRL_DUTY_LSB = 4;
   localparam int unsigned CTRL_OCFG_LSB = 6;
   localparam int unsigned TSEL_BIT = 3;
   localparam int unsigned STAT_FLAG_BIT = 0;
   localparam int unsigned STAT_LATCH_BIT = 1;

   // ==========================================================
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] VAL_RST = 16'h0000;
   localparam logic [7:0] RDATA_RST = 8'h00;

   // ==========================================================
   // Mode select codes
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_4 = 4'h6;
   localparam logic [3:0] MODE_CAP_16 = 4'h7;
   localparam logic [3:0] MODE_SET_ON_MATCH = 4'h8;
   localparam logic [3:0] MODE_CLR_ON_MATCH = 4'h9;
   localparam logic [3:0] MODE_SOFT_IRQ = 4'hA;
   localparam logic [3:0] MODE_SPECIAL = 4'hB;

   // Output configuration codes (PWM only)
   localparam logic [1:0] OCFG_SINGLE = 2'h0;
   localparam logic [1:0] OCFG_FWD = 2'h1;
   localparam logic [1:0] OCFG_HALF = 2'h2;
   localparam logic [1:0] OCFG_REV = 2'h3;

   // Prescaler terminal counts and count step
   localparam logic [1:0] PRESC4_LAST = 2'h3;
   localparam logic [3:0] PRESC16_LAST = 4'hF;
   localparam logic [3:0] PRESC_STEP = 4'h1;

   // ==========================================================
   // Mode decoding
   function automatic logic is_capture(input logic [3:0] m);
      is_capture = (m[3:2] == 2'h1);
   endfunction

   function automatic logic is_compare(input logic [3:0] m);
      is_compare = (m == MODE_TOGGLE) || (m[3:2] == 2'h2);
   endfunction

   function automatic logic is_pwm(input logic [3:0] m);
      is_pwm = (m[3:2] == 2'h3);
   endfunction

endpackage

// >>> rtl/ecm_capture_event.sv
/*
   Pin synchroniser, edge detector and capture prescaler.
   Assumes the pin is asynchronous and the mode comes from the control register.
*/
`timescale 1ns/1ps

module ecm_capture_event
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Pin and mode
   input wire logic pin_i,
   input wire logic [3:0] mode_i,
   // Event
   output logic capture_o
);

   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
      logic [3:0] presc;
      logic capture;
   } ecm_evt_s;

   ecm_evt_s s;
   ecm_evt_s next_s;
   logic rise;
   logic fall;

   // ==========================================================
   // Next state
   always_comb
   begin
      next_s = s;
      next_s.sync1 = pin_i;
      next_s.sync2 = s.sync1;
      next_s.prev = s.sync2;
      rise = s.sync2 & ~s.prev;
      fall = ~s.sync2 & s.prev;
      next_s.capture = 1'b0;
      if (!ecm_pkg::is_capture(mode_i))
      begin
         next_s.presc = 4'h0;
      end
      else
      begin
         case (mode_i)
            ecm_pkg::MODE_CAP_FALL: next_s.capture = fall;
            ecm_pkg::MODE_CAP_RISE: next_s.capture = rise;
            ecm_pkg::MODE_CAP_4:
            begin
               if (rise)
               begin
                  next_s.capture = (s.presc[1:0] == ecm_pkg::PRESC4_LAST);
                  next_s.presc = s.presc + ecm_pkg::PRESC_STEP;
               end
            end
            ecm_pkg::MODE_CAP_16:
            begin
               if (rise)
               begin
                  next_s.capture = (s.presc == ecm_pkg::PRESC16_LAST);
                  next_s.presc = s.presc + ecm_pkg::PRESC_STEP;
               end
            end
            default: next_s.capture = 1'b0;
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         s <= '0;
      else
         s <= next_s;
   end

   assign capture_o = s.capture;

endmodule

// >>> test/ecm_mode_props.sv
/*
   Port checker for the capture/compare mode unit.
   Assumes one clock domain and a bind onto ecm_mode_unit.
*/
`timescale 1ns/1ps

module ecm_mode_props
(
   // Clock, reset and register port
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [2:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Pins
   input wire logic pwm_mod_i,
   input wire logic capture_compare_pin_i,
   input wire logic capture_compare_pin_o,
   input wire logic capture_compare_pin_oe_o,
   input wire logic pwm_out_b_o,
   input wire logic pwm_out_c_oe_o,
   input wire logic pwm_out_d_oe_o,
   // Events
   input wire logic match_capture_flag_o,
   input wire logic timer_one_reset_o,
   input wire logic timer_three_reset_o,
   input wire logic adc_start_o
);
   // ==========================================
   // Shadow of control and timer select writes
   logic [7:0] ctrl_q;
   logic tsel_q;
   wire logic flag_clr = reg_wr_i && reg_addr_i == 3'h4 && reg_wdata_i[0];
   wire logic pwm_q = ctrl_q[3:2] == 2'h3;

   always_ff @(posedge core_clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         ctrl_q <= 8'h00;
         tsel_q <= 1'b0;
      end
      else if (reg_wr_i)
      begin
         if (reg_addr_i == 3'h0) ctrl_q <= reg_wdata_i;
         if (reg_addr_i == 3'h3) tsel_q <= reg_wdata_i[3];
      end

   // ==========================================
   // Properties
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   // Rise seen with the rising capture mode held through the pipeline
   sequence s_rise_held;
      $rose(capture_compare_pin_i) && ctrl_q[3:0] == 4'h5 ##1 (ctrl_q[3:0] == 4'h5) [*3];
   endsequence

   chk_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside the read answer cycle");
   chk_cap_rise: assert property (s_rise_held |=> match_capture_flag_o)
      else $error("rising edge capture did not set the flag");
   chk_flag_sticky: assert property (match_capture_flag_o && !flag_clr |=> match_capture_flag_o)
      else $error("flag dropped without a clear");
   chk_adc_single: assert property (adc_start_o |=> !adc_start_o)
      else $error("converter start longer than one cycle");
   chk_adc_with_reset: assert property (adc_start_o |-> (timer_one_reset_o != timer_three_reset_o) && match_capture_flag_o)
      else $error("special event without one timer reset and flag");
   chk_t1_reset_src: assert property (timer_one_reset_o |-> $past(ctrl_q[3:0]) == 4'hB && !$past(tsel_q))
      else $error("timer one reset outside its special event");
   chk_t3_reset_src: assert property (timer_three_reset_o |-> $past(ctrl_q[3:0]) == 4'hB && $past(tsel_q))
      else $error("timer three reset outside its special event");
   // Pin outputs are registered from the written control, so they line up with the shadow itself
   chk_pin_released: assert property ((ctrl_q[3:2] == 2'h1 || ctrl_q[3:1] == 3'h5
      || ctrl_q[3:0] == 4'h0) |-> !capture_compare_pin_oe_o)
      else $error("pin driven in a mode that leaves it to the port");
   chk_pwm_single: assert property (pwm_q && ctrl_q[7:6] == 2'h0 |->
      capture_compare_pin_o == ($past(pwm_mod_i) ^ ctrl_q[1])
      && pwm_out_b_o == ($past(pwm_mod_i) ^ ctrl_q[0]))
      else $error("single output polarity wrong");
   chk_pwm_half: assert property (pwm_q && ctrl_q[7:6] == 2'h2 |-> !pwm_out_c_oe_o && !pwm_out_d_oe_o
      && pwm_out_b_o != ($past(pwm_mod_i) ^ ctrl_q[0]))
      else $error("half bridge outputs wrong");
endmodule

bind ecm_mode_unit ecm_mode_props chk_u
(
   .core_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pwm_mod_i,
   .capture_compare_pin_i, .capture_compare_pin_o, .capture_compare_pin_oe_o, .pwm_out_b_o,
   .pwm_out_c_oe_o, .pwm_out_d_oe_o, .match_capture_flag_o, .timer_one_reset_o, .timer_three_reset_o,
   .adc_start_o
);

// >>> test/ecm_timer_model.sv
/*
   Timer count sources facing the mode unit.
   Assumes the bench loads the counts; they move only on the core clock.
*/
`timescale 1ns/1ps

module ecm_timer_model
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // Bench loading
   input wire logic load_i,
   input wire logic [15:0] t1_load_i,
   input wire logic [15:0] t3_load_i,
   // Unit side
   input wire logic timer_one_reset_i,
   input wire logic timer_three_reset_i,
   output logic [15:0] timer_one_count_o,
   output logic [15:0] timer_three_count_o
);
   // Counts held between loads so captured values are known
   // synchronous timer mode
   always_ff @(posedge core_clk_i or negedge rstn_i)
      if (!rstn_i)
      begin
         timer_one_count_o <= 16'h0000;
         timer_three_count_o <= 16'h0000;
      end
      else
      begin
         if (timer_one_reset_i) timer_one_count_o <= 16'h0000;
         else if (load_i) timer_one_count_o <= t1_load_i;
         if (timer_three_reset_i) timer_three_count_o <= 16'h0000;
         else if (load_i) timer_three_count_o <= t3_load_i;
      end
endmodule

// >>> test/enhanced_capture_unit_mode_decode_and_capture_tb_top.sv
/*
   Self-checking bench for the capture/compare mode unit.
   Assumes the timer model as far side; the bench drives the outside pin.
*/
`timescale 1ns/1ps

module enhanced_capture_unit_mode_decode_and_capture_tb_top;
   typedef struct packed {logic [7:0] c; logic m; logic [3:0] lv; logic [3:0] oe;} ecm_pwm_row_s;
   typedef struct packed {logic [3:0] m; logic oe; logic lv0; logic lv1; logic pls;} ecm_cmp_row_s;
   logic core_clk_i;
   logic rstn_i;
   logic [2:0] reg_addr_i;
   logic [7:0] reg_wdata_i;
   logic reg_wr_i;
   logic reg_rd_i;
   logic [7:0] reg_rdata_o;
   logic pwm_mod_i;
   logic [15:0] t1_cnt, t3_cnt, t1_ld, t3_ld;
   logic pin_o, pin_oe, b_o, b_oe, c_o, c_oe, d_o, d_oe;
   logic flag, t1_rst, t3_rst, adc;
   logic load;
   logic ext_pin;
   logic [7:0] adc_cnt = 8'h00;
   logic [7:0] p0;
   logic [7:0] lo;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   // Shared pin: unit drives while enabled, outside source otherwise
   wire logic pin_w = pin_oe ? pin_o : ext_pin;
   ecm_pwm_row_s pwm_rows [8] = '{'{8'h0C, 1'b1, 4'hF, 4'hF}, '{8'h0D, 1'b1, 4'hA, 4'hF},
      '{8'h0E, 1'b1, 4'h5, 4'hF}, '{8'h0F, 1'b0, 4'hF, 4'hF}, '{8'h4C, 1'b0, 4'h8, 4'hF},
      '{8'h8D, 1'b1, 4'hC, 4'hC}, '{8'hCE, 1'b1, 4'hC, 4'hF}, '{8'hCC, 1'b0, 4'h2, 4'hF}};
   ecm_cmp_row_s cmp_rows [5] = '{'{4'h8, 1'b1, 1'b0, 1'b1, 1'b0}, '{4'h9, 1'b1, 1'b1, 1'b0, 1'b0},
      '{4'h2, 1'b1, 1'b0, 1'b1, 1'b0}, '{4'hA, 1'b0, 1'b0, 1'b0, 1'b0}, '{4'hB, 1'b0, 1'b0, 1'b0, 1'b1}};
   logic [3:0] pm [2] = '{4'h6, 4'h7};
   int pn [2] = '{4, 16};

   ecm_mode_unit dut_u (.core_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
      .timer_one_count_i(t1_cnt), .timer_three_count_i(t3_cnt), .pwm_mod_i, .capture_compare_pin_i(pin_w),
      .capture_compare_pin_o(pin_o), .capture_compare_pin_oe_o(pin_oe), .pwm_out_b_o(b_o), .pwm_out_b_oe_o(b_oe),
      .pwm_out_c_o(c_o), .pwm_out_c_oe_o(c_oe), .pwm_out_d_o(d_o), .pwm_out_d_oe_o(d_oe),
      .match_capture_flag_o(flag), .timer_one_reset_o(t1_rst), .timer_three_reset_o(t3_rst), .adc_start_o(adc));
   ecm_timer_model far_u (.core_clk_i, .rstn_i, .load_i(load), .t1_load_i(t1_ld), .t3_load_i(t3_ld),
      .timer_one_reset_i(t1_rst), .timer_three_reset_i(t3_rst), .timer_one_count_o(t1_cnt),
      .timer_three_count_o(t3_cnt));

   // ==========================================
   // Clock, cycle limit and pulse counting
   initial
   begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end

   always @(posedge core_clk_i)
   begin
      cyc <= cyc + 1;
      if (adc) adc_cnt <= adc_cnt + 8'h01;
      if (cyc == 20000)
      begin
         error_cnt++;
         stop_test();
      end
   end

   // ==========================================
   // Tasks
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e)
      begin
         error_cnt++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask

   task automatic rd16(output logic [15:0] v);
      logic [7:0] l;
      logic [7:0] h;
      rd(3'h1, l);
      rd(3'h2, h);
      v = {h, l};
   endtask

   task automatic ld(input logic [15:0] a, input logic [15:0] b);
      @(posedge core_clk_i);
      t1_ld <= a;
      t3_ld <= b;
      load <= 1'b1;
      @(posedge core_clk_i);
      load <= 1'b0;
   endtask

   // Equality rises once, then the timer moves away again
   task automatic hit(input logic [15:0] v);
      ld(v, t3_ld);
      repeat (4) @(posedge core_clk_i);
      ld(16'h0000, t3_ld);
      #1;
   endtask

   // Pin held at least three cycles per level
   task automatic edges(input int n);
      repeat (n)
      begin
         @(posedge core_clk_i);
         ext_pin <= 1'b1;
         repeat (3) @(posedge core_clk_i);
         ext_pin <= 1'b0;
         repeat (5) @(posedge core_clk_i);
      end
      #1;
   endtask

   task automatic stop_test();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      logic [15:0] v;
      rstn_i = 1'b0;
      reg_addr_i = 3'h0;
      reg_wdata_i = 8'h00;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      pwm_mod_i = 1'b0;
      ext_pin = 1'b0;
      load = 1'b0;
      t1_ld = 16'h0000;
      t3_ld = 16'h0000;
      repeat (10) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      foreach (pwm_rows[i])
      begin
         wr(3'h0, pwm_rows[i].c);
         pwm_mod_i <= pwm_rows[i].m;
         repeat (2) @(posedge core_clk_i);
         #1;
         chk({pin_o, b_o, c_o, d_o} & {pin_oe, b_oe, c_oe, d_oe}, pwm_rows[i].lv);
         chk({pin_oe, b_oe, c_oe, d_oe}, pwm_rows[i].oe);
      end
      wr(3'h1, 8'h40);
      wr(3'h2, 8'h00);
      foreach (cmp_rows[i])
      begin
         wr(3'h0, 8'h00);
         wr(3'h0, {4'h0, cmp_rows[i].m});
         wr(3'h4, 8'h01);
         repeat (2) @(posedge core_clk_i);
         #1;
         chk(pin_o & pin_oe, cmp_rows[i].lv0 & cmp_rows[i].oe);
         chk(pin_oe, cmp_rows[i].oe);
         p0 = adc_cnt;
         hit(16'h0040);
         chk(pin_o & pin_oe, cmp_rows[i].lv1);
         chk(flag, 1'b1);
         chk(adc_cnt - p0, cmp_rows[i].pls);
      end
      // Special event on timer three clears that timer only
      wr(3'h3, 8'h08);
      ld(16'h1111, 16'h0040);
      repeat (3) @(posedge core_clk_i);
      #1;
      chk(t3_cnt, 16'h0000);
      chk(t1_cnt, 16'h1111);
      wr(3'h3, 8'h00);
      // Capture with timer one, then overwrite with timer three
      wr(3'h0, 8'h00);
      ld(16'h1234, 16'hBEEF);
      wr(3'h0, 8'h05);
      wr(3'h4, 8'h01);
      edges(1);
      rd16(v);
      chk(v, 16'h1234);
      chk(flag, 1'b1);
      wr(3'h3, 8'h08);
      edges(1);
      rd16(v);
      chk(v, 16'hBEEF);
      wr(3'h4, 8'h01);
      #1;
      chk(flag, 1'b0);
      wr(3'h3, 8'h00);
      wr(3'h0, 8'h04);
      wr(3'h4, 8'h01);
      ld(16'h0ABC, 16'hBEEF);
      edges(1);
      rd16(v);
      chk(v, 16'h0ABC);
      // Partial count left behind must be cleared by turning off
      foreach (pm[i])
      begin
         edges(2);
         wr(3'h0, 8'h00);
         wr(3'h0, {4'h0, pm[i]});
         wr(3'h4, 8'h01);
         edges(pn[i] - 1);
         chk(flag, 1'b0);
         edges(1);
         chk(flag, 1'b1);
      end
      // Reset in mid-run while outputs are driven
      wr(3'h0, 8'h0C);
      pwm_mod_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'b0;
      #1;
      chk({pin_oe, b_oe, c_oe, d_oe, flag}, 5'h00);
      repeat (2) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      rd(3'h0, lo);
      chk(lo, ecm_pkg::CTRL_RST);
      rd16(v);
      chk(v, ecm_pkg::VAL_RST);
      rd(3'h5, lo);
      chk(lo, 8'h00);
      stop_test();
   end
endmodule
